/* rtl/wra_pkg.sv */
// Shared constants and helpers for the weight reading averager
// Overview of operation
// - Each stage averages a configured depth of 1 to 256 readings.
// - One output per input reading; averaging only slows settling.
// - Stage one averages raw readings, stage two averages stage one outputs.
// - With both depths at 1 the output equals each reading unchanged.
// - Vibration mode tracks vibration period and averages over it instead.
// - Vibration mode drives both stages together.
// - Band threshold is in display divisions; beyond it a reading is out of band.
// - Averaging is suspended only after the configured run of out-of-band readings.
// - On override the output jumps straight to the new reading.
// - Threshold of zero (none) disables the override completely.
package wra_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_DEPTH = 8'h00;
  localparam logic [7:0] ADDR_BAND = 8'h04;
  localparam logic [7:0] ADDR_DIV = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0c;
  localparam logic [7:0] ADDR_VALUE = 8'h10;
  localparam logic [7:0] ADDR_INFO = 8'h14;
  // Implemented bits of each writable register
  localparam logic [31:0] MASK_DEPTH = 32'h01ff01ff;
  localparam logic [31:0] MASK_BAND = 32'h00ffffff;
  localparam logic [31:0] MASK_DIV = 32'h0000ffff;
  localparam logic [31:0] MASK_MODE = 32'h00000001;
  // Values after reset
  localparam logic [31:0] RST_DEPTH = 32'h00010001;
  localparam logic [31:0] RST_BAND = 32'h00010000;
  localparam logic [31:0] RST_DIV = 32'h00000001;
  localparam logic [31:0] RST_MODE = 32'h00000000;
  // Field positions
  localparam int DEPTH1_LSB = 0;
  localparam int DEPTH2_LSB = 16;
  localparam int THR_LSB = 0;
  localparam int RUN_LSB = 16;
  localparam int INFO_RUN_LSB = 16;
  // Depth limits
  localparam logic [8:0] DEPTH_MIN = 9'h001;
  localparam logic [8:0] DEPTH_MAX = 9'h100;

  // Forces any depth code into the legal 1..256 range
  function automatic logic [8:0] clamp_depth(input logic [8:0] d);
    if (d < DEPTH_MIN) begin
      return DEPTH_MIN;
    end
    if (d > DEPTH_MAX) begin
      return DEPTH_MAX;
    end
    return d;
  endfunction
endpackage

/* rtl/avg_if.sv */
// Handshake between the control logic and one averaging stage
`timescale 1ns/1ps
interface avg_if #(parameter int W = 24);
  logic start;
  logic restart;
  logic [8:0] depth;
  logic signed [W-1:0] din;
  logic done;
  logic signed [W-1:0] dout;
  modport ctrl(output start, restart, depth, din, input done, dout);
  modport stage(input start, restart, depth, din, output done, dout);
endinterface

/* rtl/avg_stage.sv */
// One moving-average stage with a sequential divider
`timescale 1ns/1ps
module avg_stage #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control side
  avg_if.stage s
);
  localparam int SW = W + 9;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_DIV, ST_DONE} stage_state_t;
  stage_state_t state;
  logic signed [W-1:0] mem [256];
  logic [7:0] ptr;
  logic [8:0] cnt;
  logic signed [SW-1:0] sum;
  logic [SW-1:0] quo;
  logic [SW:0] rem;
  logic neg;
  logic [5:0] bits;
  logic signed [W-1:0] oldest;
  logic [SW:0] trial;
  logic [SW:0] divisor;
  logic fits;

  // Oldest sample only leaves once the window is full
  assign oldest = (cnt == s.depth) ? mem[ptr] : '0;
  assign trial = {rem[SW-1:0], quo[SW-1]};
  assign divisor = (SW+1)'(cnt);
  assign fits = trial >= divisor;

  // Running window sum, fill count and write pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum <= '0;
      cnt <= '0;
      ptr <= '0;
    end else if (s.start) begin
      if (s.restart) begin
        sum <= SW'(s.din);
        cnt <= 9'h001;
        ptr <= (s.depth == 9'h001) ? 8'h00 : 8'h01;
      end else begin
        sum <= sum + SW'(s.din) - SW'(oldest);
        cnt <= (cnt == s.depth) ? cnt : cnt + 9'h001;
        ptr <= ({1'b0, ptr} == s.depth - 9'h001) ? 8'h00 : ptr + 8'h01;
      end
    end
  end

  // Sample store, no reset needed since cnt guards it
  always_ff @(posedge clk_i) begin
    if (s.start) begin
      mem[s.restart ? 8'h00 : ptr] <= s.din;
    end
  end

  // Divide the sum by the fill count, one bit a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      quo <= '0;
      rem <= '0;
      neg <= 1'b0;
      bits <= '0;
      s.done <= 1'b0;
      s.dout <= '0;
    end else begin
      s.done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (s.start) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          neg <= sum[SW-1];
          quo <= sum[SW-1] ? SW'(-sum) : SW'(sum);
          rem <= '0;
          bits <= 6'(SW);
          state <= ST_DIV;
        end
        ST_DIV: begin
          rem <= fits ? trial - divisor : trial;
          quo <= {quo[SW-2:0], fits};
          bits <= bits - 6'h01;
          if (bits == 6'h01) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Average of W-bit samples always fits in W bits
          s.dout <= neg ? W'(-quo) : W'(quo);
          s.done <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  a_depth_range: assert property (@(posedge clk_i) disable iff (rst_i)
    s.start |=> (cnt >= 9'h001) && (cnt <= s.depth) && (cnt <= 9'h100))
    else $error("stage fill count outside depth");
  a_restart_seed: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.start && s.restart) |=> (cnt == 9'h001) && (sum == SW'($past(s.din))))
    else $error("stage restart did not seed from new reading");
endmodule

/* rtl/skid_fifo.sv */
// Small valid/ready buffer on the output path
`timescale 1ns/1ps
module skid_fifo #(
  parameter int W = 25,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready_o = count != CW'(DEPTH);
  assign out_valid_o = count != '0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rptr];

  // Pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  // Entry storage, reset so the data output is defined
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (push) begin
      mem[wptr] <= in_data_i;
    end
  end
endmodule

/* rtl/weight_reading_averager.sv */
// Two-stage weight averager with band override and vibration mode
`timescale 1ns/1ps
module weight_reading_averager #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Raw readings from the converter
  input wire logic rd_valid_i,
  input wire logic signed [W-1:0] rd_data_i,
  output logic rd_ready_o,
  // Filtered weight toward the display
  output logic wt_valid_o,
  output logic signed [W-1:0] wt_data_o,
  output logic wt_override_o,
  input wire logic wt_ready_i
);
  typedef enum logic [1:0] {ST_IDLE, ST_S1, ST_S2, ST_PUSH} ctrl_state_t;
  ctrl_state_t state;

  logic [31:0] reg_depth;
  logic [31:0] reg_band;
  logic [31:0] reg_div;
  logic [31:0] reg_mode;
  logic wb_req;
  logic [8:0] first_stage_depth;
  logic [8:0] second_stage_depth;
  logic [15:0] override_band_threshold;
  logic [7:0] override_run_count;
  logic [15:0] display_division_size;
  logic vibration_suppress_enable;

  logic signed [W-1:0] filt;
  logic signed [W-1:0] reading;
  logic signed [W-1:0] result;
  logic ovr_flag;
  logic [7:0] run;
  logic accept;
  logic signed [W:0] dev;
  logic [W:0] mag;
  logic [32:0] band;
  logic oob;
  logic [7:0] run_need;
  logic hit;
  logic [8:0] eff1;
  logic [8:0] eff2;
  logic [8:0] used1;
  logic [8:0] used2;
  logic restart_now;
  logic prev_pos;
  logic [8:0] since;
  logic [8:0] period;
  logic fifo_ready;
  logic [W:0] fifo_out;

  avg_if #(.W(W)) s1 ();
  avg_if #(.W(W)) s2 ();

  // Merges written byte lanes into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  // Configuration fields, depths kept legal whatever software writes
  assign first_stage_depth = wra_pkg::clamp_depth(reg_depth[wra_pkg::DEPTH1_LSB +: 9]);
  assign second_stage_depth = wra_pkg::clamp_depth(reg_depth[wra_pkg::DEPTH2_LSB +: 9]);
  assign override_band_threshold = reg_band[wra_pkg::THR_LSB +: 16];
  assign override_run_count = reg_band[wra_pkg::RUN_LSB +: 8];
  assign display_division_size = reg_div[15:0];
  assign vibration_suppress_enable = reg_mode[0];

  // Single-wait-state slave; ack drops the cycle after it rose
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Register writes, only on the acknowledging request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_depth <= wra_pkg::RST_DEPTH;
      reg_band <= wra_pkg::RST_BAND;
      reg_div <= wra_pkg::RST_DIV;
      reg_mode <= wra_pkg::RST_MODE;
    end else if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        wra_pkg::ADDR_DEPTH: reg_depth <= merge(reg_depth, wb_dat_i, wb_sel_i,
                                                wra_pkg::MASK_DEPTH);
        wra_pkg::ADDR_BAND: reg_band <= merge(reg_band, wb_dat_i, wb_sel_i,
                                              wra_pkg::MASK_BAND);
        wra_pkg::ADDR_DIV: reg_div <= merge(reg_div, wb_dat_i, wb_sel_i, wra_pkg::MASK_DIV);
        wra_pkg::ADDR_MODE: reg_mode <= merge(reg_mode, wb_dat_i, wb_sel_i,
                                              wra_pkg::MASK_MODE);
        default: begin
        end
      endcase
    end
  end

  // Read data; unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req) begin
      case (wb_adr_i)
        wra_pkg::ADDR_DEPTH: wb_dat_o <= reg_depth;
        wra_pkg::ADDR_BAND: wb_dat_o <= reg_band;
        wra_pkg::ADDR_DIV: wb_dat_o <= reg_div;
        wra_pkg::ADDR_MODE: wb_dat_o <= reg_mode;
        wra_pkg::ADDR_VALUE: wb_dat_o <= 32'(filt);
        wra_pkg::ADDR_INFO: wb_dat_o <= {8'h00, run, 7'h00, period};
        default: wb_dat_o <= '0;
      endcase
    end else begin
      wb_dat_o <= '0;
    end
  end

  // Deviation of the new reading from the shown weight
  assign accept = rd_valid_i && (state == ST_IDLE);
  assign rd_ready_o = state == ST_IDLE;
  assign dev = (W+1)'(rd_data_i) - (W+1)'(filt);
  assign mag = dev[W] ? (W+1)'(-dev) : dev;
  assign band = 33'(override_band_threshold) * 33'(display_division_size);
  // Zero threshold means no override at all
  assign oob = (override_band_threshold != 16'h0000) && (33'(mag) > band);
  // A run count of zero is treated as one
  assign run_need = (override_run_count == 8'h00) ? 8'h01 : override_run_count;
  assign hit = oob && ((9'(run) + 9'h001) >= 9'(run_need));

  // Vibration mode swaps both depths for the tracked period
  assign eff1 = vibration_suppress_enable ? period : first_stage_depth;
  assign eff2 = vibration_suppress_enable ? period : second_stage_depth;
  // Window geometry must be rebuilt whenever a depth changes
  assign restart_now = hit || (eff1 != used1) || (eff2 != used2);

  // Consecutive out-of-band run counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= '0;
    end else if (accept) begin
      if (!oob || hit) begin
        run <= '0;
      end else if (run != 8'hff) begin
        run <= run + 8'h01;
      end
    end
  end

  // Period of a repeating vibration from upward crossings of the shown weight;
  // averaging over a whole period cancels a periodic disturbance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_pos <= 1'b0;
      since <= 9'h001;
      period <= wra_pkg::DEPTH_MIN;
    end else if (accept) begin
      prev_pos <= !dev[W];
      if (!dev[W] && !prev_pos) begin
        period <= wra_pkg::clamp_depth(since);
        since <= 9'h001;
      end else if (since != wra_pkg::DEPTH_MAX) begin
        since <= since + 9'h001;
      end
    end
  end

  // Cascade sequencer: raw reading into stage one, its result into stage two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      reading <= '0;
      result <= '0;
      filt <= '0;
      ovr_flag <= 1'b0;
      used1 <= wra_pkg::DEPTH_MIN;
      used2 <= wra_pkg::DEPTH_MIN;
      s1.start <= 1'b0;
      s1.restart <= 1'b0;
      s1.depth <= wra_pkg::DEPTH_MIN;
      s1.din <= '0;
      s2.start <= 1'b0;
      s2.restart <= 1'b0;
      s2.depth <= wra_pkg::DEPTH_MIN;
      s2.din <= '0;
    end else begin
      s1.start <= 1'b0;
      s2.start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            reading <= rd_data_i;
            ovr_flag <= hit;
            used1 <= eff1;
            used2 <= eff2;
            s1.start <= 1'b1;
            s1.restart <= restart_now;
            s1.depth <= eff1;
            s1.din <= rd_data_i;
            s2.restart <= restart_now;
            s2.depth <= eff2;
            state <= ST_S1;
          end
        end
        ST_S1: begin
          if (s1.done) begin
            s2.start <= 1'b1;
            s2.din <= s1.dout;
            state <= ST_S2;
          end
        end
        ST_S2: begin
          if (s2.done) begin
            // A restarted chain yields the reading itself, so an override jumps
            result <= s2.dout;
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          // Output stalls here, holding off new readings, rather than dropping one
          if (fifo_ready) begin
            filt <= result;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  avg_stage #(.W(W)) u_stage1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(s1.stage)
  );

  avg_stage #(.W(W)) u_stage2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(s2.stage)
  );

  skid_fifo #(.W(W + 1), .DEPTH(2)) u_out_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(state == ST_PUSH),
    .in_data_i({ovr_flag, result}),
    .in_ready_o(fifo_ready),
    .out_valid_o(wt_valid_o),
    .out_data_o(fifo_out),
    .out_ready_i(wt_ready_i)
  );

  assign wt_data_o = fifo_out[W-1:0];
  assign wt_override_o = fifo_out[W];

  a_rate_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    accept |-> ##[1:120] (state == ST_PUSH))
    else $error("reading did not produce an output");
  a_cascade_feed: assert property (@(posedge clk_i) disable iff (rst_i)
    s1.done && (state == ST_S1) |=> s2.start && (s2.din == $past(s1.dout)))
    else $error("stage two not fed from stage one");
  a_depth_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_PUSH) && (used1 == 9'h001) && (used2 == 9'h001) |-> (result == reading))
    else $error("unity depths altered the reading");
  a_vib_both: assert property (@(posedge clk_i) disable iff (rst_i)
    vibration_suppress_enable |-> (eff1 == eff2) && (eff1 == period))
    else $error("vibration mode not applied to both stages");
  a_band_in: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && (33'(mag) <= band) |=> (run == 8'h00) && !ovr_flag)
    else $error("in-band reading counted as out of band");
  a_run_short: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && oob && ((9'(run) + 9'h001) < 9'(run_need))
      |=> !ovr_flag && (run == $past(run) + 8'h01))
    else $error("override before the run completed");
  a_override_jump: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_PUSH) && ovr_flag |-> (result == reading))
    else $error("override did not jump to the reading");
  a_none_off: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && (override_band_threshold == 16'h0000) |=> !ovr_flag)
    else $error("override fired with threshold none");
  a_run_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && !oob |=> (run == 8'h00))
    else $error("run counter not cleared in band");
  a_override_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && hit |=> s1.restart && s2.restart && s1.start)
    else $error("override did not restart both stages");
endmodule

/* tb/adc_model.sv */
// Converter model that hands queued readings to the averager
`timescale 1ns/1ps
module adc_model #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Reading handshake
  input wire logic ready_i,
  output logic valid_o,
  output logic [W-1:0] data_o
);
  logic [W-1:0] q[$];
  int gap = 0;
  int idle = 0;
  initial begin
    valid_o = 1'b0;
    data_o = '0;
  end
  // Hold a reading until taken; a released line is scrambled, never left stale
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
      idle <= 0;
    end else if (!valid_o && q.size() > 0 && idle >= gap) begin
      valid_o <= 1'b1;
      data_o <= q.pop_front();
    end else begin
      idle <= idle + 1;
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the weight reading averager
`timescale 1ns/1ps
module testbench;
  localparam int W = 24;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_rdat;
  logic wb_ack, rd_valid, rd_ready, wt_valid, wt_override;
  logic wt_ready = 1'b1;
  logic signed [W-1:0] rd_data, wt_data;
  int err_count = 0, total_checks = 0;
  // Reference model state
  int h1[$], h2[$], exp_d[$];
  bit exp_o[$];
  int d1 = 1, d2 = 1, thr = 0, dv = 1, runlim = 1, run = 0, last_out = 0;
  bit restart = 1'b0;

  always #5 clk_i = ~clk_i;

  weight_reading_averager #(.W(W)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .rd_ready_o(rd_ready), .wt_valid_o(wt_valid),
    .wt_data_o(wt_data), .wt_override_o(wt_override), .wt_ready_i(wt_ready));
  adc_model #(.W(W)) adc (.clk_i(clk_i), .rst_i(rst_i), .ready_i(rd_ready),
    .valid_o(rd_valid), .data_o(rd_data));

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    total_checks++;
    if (got !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One classic cycle; request held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) chk("wb_ack", 32'h1, 32'h0);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, 4'hf, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 4'hf, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask

  // A change of effective depth restarts both stages
  task automatic set_depth(input int a, input int b);
    wr(wra_pkg::ADDR_DEPTH, {7'h0, 9'(b), 7'h0, 9'(a)});
    if (a != d1 || b != d2) restart = 1'b1;
    d1 = a;
    d2 = b;
  endtask

  function automatic int mean(ref int h[$]);
    int s = 0;
    foreach (h[i]) s += h[i];
    return s / h.size();
  endfunction

  // Predict the word for one reading, then queue the reading
  task automatic send(input int x);
    bit ovr;
    ovr = 1'b0;
    if (thr != 0) begin
      if ((x > last_out ? x - last_out : last_out - x) > thr * dv) begin
        run++;
        if (run >= runlim) begin
          ovr = 1'b1;
          run = 0;
          restart = 1'b1;
        end
      end else begin
        run = 0;
      end
    end
    if (restart) begin
      h1.delete();
      h2.delete();
      restart = 1'b0;
    end
    h1.push_back(x);
    if (h1.size() > d1) void'(h1.pop_front());
    h2.push_back(mean(h1));
    if (h2.size() > d2) void'(h2.pop_front());
    last_out = mean(h2);
    exp_d.push_back(last_out);
    exp_o.push_back(ovr);
    adc.q.push_back(W'(x));
  endtask

  // Compare every word the display takes, in order
  always @(posedge clk_i) begin
    if (wt_valid === 1'b1 && wt_ready === 1'b1) begin
      if (exp_d.size() == 0) begin
        chk("extra word", 32'h0, 32'h1);
      end else begin
        chk("wt_data", exp_d[0] & 32'hffffff, {8'h0, wt_data});
        chk("wt_override", {31'h0, exp_o[0]}, {31'h0, wt_override});
        void'(exp_d.pop_front());
        void'(exp_o.pop_front());
      end
    end
  end

  task automatic drain();
    int n;
    n = 0;
    while (exp_d.size() > 0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) chk("drain", 32'h0, 32'(exp_d.size()));
  endtask

  task automatic test_regs();
    logic [31:0] q;
    rdc(wra_pkg::ADDR_DEPTH, wra_pkg::RST_DEPTH);
    rdc(wra_pkg::ADDR_BAND, wra_pkg::RST_BAND);
    rdc(wra_pkg::ADDR_DIV, wra_pkg::RST_DIV);
    rdc(wra_pkg::ADDR_MODE, wra_pkg::RST_MODE);
    wr(8'h20, 32'hffffffff);
    rdc(8'h20, 32'h0);
    wr(wra_pkg::ADDR_VALUE, 32'h00ffffff);
    rdc(wra_pkg::ADDR_VALUE, 32'h0);
    wb_xfer(1'b1, wra_pkg::ADDR_DIV, 4'h2, 32'h0000ab00, q);
    rdc(wra_pkg::ADDR_DIV, 32'h0000ab01);
    wr(wra_pkg::ADDR_DIV, 32'h1);
  endtask

  // Unit depths and no band: every reading passes through unaltered
  task automatic test_passthru();
    int v[6] = '{5, -7, 8388607, -8388608, 0, 1};
    foreach (v[i]) send(v[i]);
    drain();
  endtask

  task automatic test_average();
    int v[7] = '{0, -8000, 8000, 300, 7, 7, -1};
    set_depth(3, 2);
    foreach (v[i]) send(v[i]);
    drain();
    rdc(wra_pkg::ADDR_VALUE, 32'(last_out));
  endtask

  // Band of 2 divisions of 10, run of 3; an in-band reading breaks a run,
  // the third 160 overrides, and a gap of exactly 20 stays in band
  task automatic test_override();
    int v[11] = '{100, 100, 100, 100, 130, 100, 160, 160, 160, 160, 140};
    set_depth(4, 1);
    wr(wra_pkg::ADDR_DIV, 32'd10);
    wr(wra_pkg::ADDR_BAND, 32'h00030002);
    dv = 10;
    thr = 2;
    runlim = 3;
    foreach (v[i]) send(v[i]);
    drain();
    wr(wra_pkg::ADDR_BAND, 32'h00010000);
    thr = 0;
  endtask

  // A steady load must read exactly in vibration mode
  task automatic test_vibration();
    wr(wra_pkg::ADDR_MODE, 32'h1);
    rdc(wra_pkg::ADDR_MODE, 32'h1);
    restart = 1'b1;
    repeat (6) send(50);
    drain();
    wr(wra_pkg::ADDR_MODE, 32'h0);
    restart = 1'b1;
  endtask

  // Display stalls: two words buffer, one waits, the fourth reading is held off
  task automatic test_buffer();
    set_depth(1, 1);
    adc.gap = 3;
    wt_ready <= 1'b0;
    send(11);
    send(22);
    send(33);
    send(44);
    repeat (600) @(posedge clk_i);
    chk("wt_valid", 32'h1, {31'h0, wt_valid});
    chk("rd_ready", 32'h0, {31'h0, rd_ready});
    chk("held reading", 32'h1, 32'(adc.q.size()) + {31'h0, adc.valid_o});
    wt_ready <= 1'b1;
    drain();
    @(posedge clk_i);
    chk("wt_valid empty", 32'h0, {31'h0, wt_valid});
    adc.gap = 0;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_regs();
    test_passthru();
    test_average();
    test_override();
    test_vibration();
    test_buffer();
    give_verdict();
  end

  // Watchdog well beyond the expected run of some 3000 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    chk("watchdog", 32'h0, 32'h1);
    give_verdict();
  end
endmodule
